/* pkg/sepv_regs.svh */
// Constants for the EEPROM program/verify block.
// Assumes a 125 MHz core clock; included by bare name.
// Functional notes
// - A session moves the whole 288-bit image; all of it is stored.
// - Entry starts a bulk erase; programmer waits 4 ms before data.
// - Bulk erase clears every memory location to zero first.
// - Words of 16 bits arrive LSB first, clocked by the switch input.
// - Each loaded word gets an internal write cycle, up to 50 ms.
// - Write completion shown by ack pulses, each phase at least 800 us.
// - Ack pulses continue until the programmer lowers the clock input.
// - One verify readback is allowed, only right after programming.
// - Verify: each rising clock edge shifts out a stored bit, LSB first.
// - Verify is refused unless programming happened first.
// - Words five to eight form one 64-bit field, MSB part in word eight.
`ifndef SEPV_REGS_SVH
`define SEPV_REGS_SVH
`define SEPV_IMAGE_BITS 288
`define SEPV_WORD_BITS 16
`define SEPV_WORDS 18
`define SEPV_CLK_MHZ 125
`define SEPV_SETUP_MIN_US 2000
`define SEPV_ERASE_US 4000
`define SEPV_WRITE_US 50000
`define SEPV_ACK_US 800
`define SEPV_US_CYC(us) ((us) * `SEPV_CLK_MHZ)
`define SEPV_FIELD_LO_WORD 4
`define SEPV_FIELD_HI_WORD 7
`endif

/* pkg/sepv_pkg.sv */
// Types for the EEPROM program/verify block.
// Assumes nothing outside itself.
package sepv_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_ERASE, ST_LOAD, ST_WRITE, ST_ACK, ST_VERIFY
  } sepv_state_e;
endpackage

/* rtl/sepv_mem.sv */
// Word memory holding the configuration image.
// Assumes one write and one read per cycle; read data are registered.
`timescale 1ns/100ps
module sepv_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 18,
  parameter int AW = 5
) (
  // Clock
  input wire logic clk,
  input wire logic ce,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
    if (ce) begin
      rdata_q <= mem[raddr];
    end
  end
endmodule // sepv_mem

/* rtl/sepv_prog.sv */
// Program/verify engine for the configuration EEPROM.
// Assumes the switch input and data pin come asynchronously from a
// programmer; both are synchronised before use. Data pin is three signals.
`timescale 1ns/100ps
`include "sepv_regs.svh"
module sepv_prog #(
  parameter int SETUP_CYC = `SEPV_US_CYC(`SEPV_SETUP_MIN_US),
  parameter int ERASE_CYC = `SEPV_US_CYC(`SEPV_ERASE_US),
  parameter int WRITE_CYC = `SEPV_US_CYC(`SEPV_WRITE_US),
  parameter int ACK_CYC = `SEPV_US_CYC(`SEPV_ACK_US),
  parameter int WORDS = `SEPV_WORDS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Programmer pins
  input wire logic sw_clk_in,
  input wire logic data_in,
  output logic data_out_q,
  output logic data_oen_q,
  // Status
  output logic prog_mode_q,
  output logic image_done_q,
  output logic verify_used_q,
  output logic [63:0] key_field_q
);
  localparam int CW = 24;
  localparam logic [4:0] LAST_WORD = 5'(WORDS - 1);

  sepv_pkg::sepv_state_e state_q, state_d;
  logic [1:0] clk_sync_q, dat_sync_q;
  logic clk_prev_q;
  logic [CW-1:0] cnt_q;
  logic [3:0] bit_q;
  logic [4:0] word_q;
  logic [4:0] erase_q;
  logic [15:0] shift_q;
  logic [15:0] out_q;
  logic ack_lvl_q;
  logic [15:0] rdata;

  wire sclk = clk_sync_q[1];
  wire sdat = dat_sync_q[1];
  wire rise = sclk && !clk_prev_q;
  wire fall = !sclk && clk_prev_q;
  wire cnt_done_setup = cnt_q >= CW'(SETUP_CYC);
  wire cnt_done_erase = cnt_q >= CW'(ERASE_CYC);
  wire cnt_done_write = cnt_q >= CW'(WRITE_CYC);
  wire cnt_done_ack = cnt_q >= CW'(ACK_CYC - 1);
  wire erasing = state_q == sepv_pkg::ST_ERASE;
  wire word_full = rise && bit_q == 4'hf;
  wire [15:0] word_val = {sdat, shift_q[15:1]};
  wire mem_we = erasing || state_q == sepv_pkg::ST_WRITE && cnt_q == '0;
  wire [4:0] waddr = erasing ? erase_q : word_q;
  wire [15:0] wdata = erasing ? 16'h0000 : shift_q;
  // Idle keeps word 0 on the read port so the first verify bit is ready
  wire [4:0] raddr = (state_q == sepv_pkg::ST_VERIFY) ? word_q : 5'h00;
  wire verify_go = state_q == sepv_pkg::ST_IDLE &&
                   state_d == sepv_pkg::ST_VERIFY;
  wire load_field = state_q == sepv_pkg::ST_WRITE && cnt_q == '0 &&
                    word_q >= 5'(`SEPV_FIELD_LO_WORD) &&
                    word_q <= 5'(`SEPV_FIELD_HI_WORD);
  wire [1:0] field_idx = 2'(word_q - 5'(`SEPV_FIELD_LO_WORD));

  sepv_mem #(.WIDTH(16), .DEPTH(WORDS), .AW(5)) u_mem (
    .clk(clk),
    .ce(ce),
    .we(mem_we),
    .waddr(waddr),
    .wdata(wdata),
    .raddr(raddr),
    .rdata_q(rdata)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      sepv_pkg::ST_IDLE: begin
        if (image_done_q && !verify_used_q && rise) begin
          state_d = sepv_pkg::ST_VERIFY;
        end else if (sclk && !sdat) begin
          state_d = sepv_pkg::ST_SETUP;
        end
      end
      sepv_pkg::ST_SETUP: begin
        if (!sclk) begin
          state_d = sepv_pkg::ST_IDLE;
        end else if (sdat && cnt_done_setup) begin
          state_d = sepv_pkg::ST_ERASE;
        end
      end
      sepv_pkg::ST_ERASE: begin
        if (erase_q == LAST_WORD && cnt_done_erase) begin
          state_d = sepv_pkg::ST_LOAD;
        end
      end
      sepv_pkg::ST_LOAD: begin
        if (word_full) begin
          state_d = sepv_pkg::ST_WRITE;
        end
      end
      sepv_pkg::ST_WRITE: begin
        if (cnt_done_write) begin
          state_d = sepv_pkg::ST_ACK;
        end
      end
      sepv_pkg::ST_ACK: begin
        if (!sclk) begin
          state_d = (word_q == LAST_WORD) ? sepv_pkg::ST_IDLE
                                          : sepv_pkg::ST_LOAD;
        end
      end
      sepv_pkg::ST_VERIFY: begin
        if (word_q == LAST_WORD && bit_q == 4'hf && fall) begin
          state_d = sepv_pkg::ST_IDLE;
        end
      end
      default: state_d = sepv_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_sync_q <= 2'h0;
      dat_sync_q <= 2'h0;
      clk_prev_q <= 1'b0;
    end else if (ce) begin
      clk_sync_q <= {clk_sync_q[0], sw_clk_in};
      dat_sync_q <= {dat_sync_q[0], data_in};
      clk_prev_q <= sclk;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= sepv_pkg::ST_IDLE;
      cnt_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      if (state_d != state_q || (state_q == sepv_pkg::ST_ACK &&
          cnt_done_ack)) begin
        cnt_q <= '0;
      end else if (!(&cnt_q)) begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      erase_q <= 5'h00;
    end else if (ce) begin
      if (!erasing) begin
        erase_q <= 5'h00;
      end else if (erase_q != LAST_WORD) begin
        erase_q <= erase_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_q <= 4'h0;
      word_q <= 5'h00;
      shift_q <= 16'h0000;
    end else if (ce) begin
      if (erasing || state_q == sepv_pkg::ST_IDLE && state_d ==
          sepv_pkg::ST_VERIFY) begin
        bit_q <= 4'h0;
        word_q <= 5'h00;
      end else if (state_q == sepv_pkg::ST_LOAD && rise) begin
        shift_q <= word_val;
        bit_q <= bit_q + 4'h1;
      end else if (state_q == sepv_pkg::ST_ACK && !sclk) begin
        word_q <= word_q + 5'h01;
      end else if (state_q == sepv_pkg::ST_VERIFY && fall) begin
        bit_q <= bit_q + 4'h1;
        if (bit_q == 4'hf) begin
          word_q <= word_q + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_lvl_q <= 1'b0;
      out_q <= 16'h0000;
      data_out_q <= 1'b0;
      data_oen_q <= 1'b1;
    end else if (ce) begin
      if (state_q != sepv_pkg::ST_ACK) begin
        ack_lvl_q <= 1'b1;
      end else if (cnt_done_ack) begin
        ack_lvl_q <= !ack_lvl_q;
      end
      if (verify_go) begin
        out_q <= rdata;
        data_out_q <= rdata[0];
      end else if (state_q == sepv_pkg::ST_VERIFY && rise) begin
        out_q <= (bit_q == 4'h0) ? rdata : out_q;
        data_out_q <= (bit_q == 4'h0) ? rdata[0] : out_q[bit_q];
      end else if (state_q == sepv_pkg::ST_ACK) begin
        data_out_q <= ack_lvl_q;
      end else if (state_q != sepv_pkg::ST_VERIFY) begin
        data_out_q <= 1'b0;
      end
      data_oen_q <= !(state_q == sepv_pkg::ST_ACK ||
                      state_q == sepv_pkg::ST_VERIFY);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prog_mode_q <= 1'b0;
      image_done_q <= 1'b0;
      verify_used_q <= 1'b0;
      key_field_q <= 64'h0;
    end else if (ce) begin
      prog_mode_q <= state_q inside {sepv_pkg::ST_ERASE, sepv_pkg::ST_LOAD,
                                     sepv_pkg::ST_WRITE, sepv_pkg::ST_ACK};
      if (erasing) begin
        image_done_q <= 1'b0;
        verify_used_q <= 1'b0;
        key_field_q <= 64'h0;
      end else begin
        if (state_q == sepv_pkg::ST_ACK && state_d == sepv_pkg::ST_IDLE) begin
          image_done_q <= 1'b1;
        end
        if (state_d == sepv_pkg::ST_VERIFY) begin
          verify_used_q <= 1'b1;
        end
        if (load_field) begin
          key_field_q[field_idx*16 +: 16] <= shift_q;
        end
      end
    end
  end
endmodule // sepv_prog

/* testbench/sepv_prog_assertions.sv */
// Assertions on the program/verify engine ports.
// Assumes binding onto sepv_prog.
`timescale 1ns/100ps
module sepv_prog_chk #(
  parameter int ACK_CYC = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Pins
  input wire logic sw_clk_in,
  input wire logic data_in,
  input wire logic data_out_q,
  input wire logic data_oen_q,
  // Status
  input wire logic prog_mode_q,
  input wire logic image_done_q,
  input wire logic verify_used_q,
  input wire logic [63:0] key_field_q
);
  logic last_q;
  logic [31:0] run_q;
  // Cycles since the data output last changed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_q <= 1'b0;
      run_q <= 32'h0;
    end else begin
      last_q <= data_out_q;
      run_q <= (data_out_q != last_q) ? 32'h0 : run_q + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence acking_s;
    prog_mode_q && !data_oen_q;
  endsequence
  sequence toggle_s;
    (data_out_q != last_q) ##0 acking_s ##0 !$past(data_oen_q);
  endsequence
  sequence drop_s;
    $fell(sw_clk_in) ##0 acking_s;
  endsequence
  reset_idle_a: assert property ($rose(resetn) |-> data_oen_q &&
    !prog_mode_q && !image_done_q && !verify_used_q)
    else $error("not idle after reset");
  ack_phase_a: assert property (toggle_s |-> run_q >= ACK_CYC - 1)
    else $error("ack phase short");
  ack_hold_a: assert property (acking_s ##0 sw_clk_in |=> !data_oen_q)
    else $error("ack stopped early");
  ack_release_a: assert property (drop_s |-> ##[1:6] data_oen_q)
    else $error("ack not released");
  refuse_verify_a: assert property (!data_oen_q |->
    prog_mode_q || image_done_q) else $error("drive while locked");
  verify_start_a: assert property ($rose(verify_used_q) |->
    image_done_q && !prog_mode_q) else $error("verify too early");
  verify_once_a: assert property (verify_used_q && !prog_mode_q |=>
    verify_used_q || prog_mode_q) else $error("verify rearmed");
  erase_quiet_a: assert property ($rose(prog_mode_q) |->
    data_oen_q [*8]) else $error("drive during erase");
endmodule // sepv_prog_chk

/* testbench/sepv_programmer.sv */
// Programmer model driving the switch clock and data pin.
// Assumes the bench resolves the pin; link clock period is 10 cycles.
`timescale 1ns/100ps
module sepv_programmer (
  // Timing
  input wire logic clk,
  // Pins
  input wire logic pin,
  output logic sw,
  output logic drv
);
  initial begin
    sw = 1'b0;
    drv = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic enter();
    sw = 1'b1;
    drv = 1'b0;
    tick(25);
    drv = 1'b1;
    tick(70);
    drv = 1'b0;
  endtask
  task automatic word(input logic [15:0] w);
    int n;
    n = 0;
    for (int i = 0; i < 16; i++) begin
      drv = w[i];
      sw = 1'b0;
      tick(5);
      sw = 1'b1;
      tick(5);
    end
    drv = 1'b0;
    while (pin !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    tick(35);
    sw = 1'b0;
    tick(5);
  endtask
  task automatic read_bit(output logic b);
    sw = 1'b1;
    tick(6);
    b = pin;
    sw = 1'b0;
    tick(4);
  endtask
endmodule // sepv_programmer

/* testbench/tb.sv */
// Self-checking bench for the program/verify engine.
// Assumes the programmer model and checker in this folder.
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic data_out_q, data_oen_q, prog_mode_q, image_done_q, verify_used_q;
  logic [63:0] key_field_q;
  logic sw, drv, b;
  wire pin = data_oen_q ? drv : data_out_q;
  logic [15:0] img [18];
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  sepv_prog #(.SETUP_CYC(20), .ERASE_CYC(40), .WRITE_CYC(30),
    .ACK_CYC(10), .WORDS(18)) DUT (.clk(clk), .resetn(resetn),
    .ce(ce), .sw_clk_in(sw), .data_in(pin), .data_out_q(data_out_q),
    .data_oen_q(data_oen_q), .prog_mode_q(prog_mode_q),
    .image_done_q(image_done_q), .verify_used_q(verify_used_q),
    .key_field_q(key_field_q));
  sepv_programmer P (.clk(clk), .pin(pin), .sw(sw), .drv(drv));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Clocking the pins must not start a readback
  task automatic t_locked();
    for (int i = 0; i < 4; i++) begin
      P.read_bit(b);
      chk(data_oen_q, 1'b1);
    end
  endtask
  task automatic t_program(input logic [15:0] seed);
    P.enter();
    chk(key_field_q, 64'h0);
    for (int i = 0; i < 18; i++) begin
      img[i] = seed ^ 16'(i * 16'h1359);
      P.word(img[i]);
      chk(prog_mode_q, i < 17);
    end
    chk(image_done_q, 1'b1);
    chk(key_field_q, {img[7], img[6], img[5], img[4]});
  endtask
  // A frozen block must not react to switch clocking
  task automatic t_freeze();
    ce = 1'b0;
    P.read_bit(b);
    P.read_bit(b);
    ce = 1'b1;
    repeat (4) @(negedge clk);
    chk(verify_used_q, 1'b0);
    chk(data_oen_q, 1'b1);
  endtask
  task automatic t_verify();
    for (int i = 0; i < 288; i++) begin
      P.read_bit(b);
      chk(b, img[i / 16][i % 16]);
    end
    chk(verify_used_q, 1'b1);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    t_locked();
    t_program(16'h3ac5);
    t_freeze();
    t_verify();
    t_locked();
    t_program(16'hc53a);
    wrap_up();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
endmodule // tb
bind sepv_prog sepv_prog_chk #(.ACK_CYC(ACK_CYC)) u_chk (.clk(clk),
  .resetn(resetn), .ce(ce), .sw_clk_in(sw_clk_in), .data_in(data_in),
  .data_out_q(data_out_q), .data_oen_q(data_oen_q),
  .prog_mode_q(prog_mode_q), .image_done_q(image_done_q),
  .verify_used_q(verify_used_q), .key_field_q(key_field_q));
